/* File: core/adc_window_map.vh */
// Register addresses, field positions, reset values and timing constants
`ifndef ADC_WINDOW_MAP_VH
`define ADC_WINDOW_MAP_VH
// ****************************************************************
// Special-function register addresses
// ****************************************************************
`define CONV_CTRL_ADDR 8'he8
`define CONV_CFG_ADDR 8'hbc
`define UPPER_HI_ADDR 8'hc5
`define UPPER_LO_ADDR 8'hc4
`define LOWER_HI_ADDR 8'hc7
`define LOWER_LO_ADDR 8'hc6
`define RESULT_HI_ADDR 8'hbf
`define RESULT_LO_ADDR 8'hbe
// ****************************************************************
// Fields and reset values
// ****************************************************************
`define CTRL_START_BIT 4
`define CTRL_DONE_BIT 5
`define CTRL_BUSY_BIT 3
`define CTRL_HIT_BIT 2
`define CTRL_ENABLE_BIT 7
`define CFG_DIV_MSB 7
`define CFG_DIV_LSB 5
`define BYTE_RESET 8'h00
`define UPPER_RESET 8'hff
`define CFG_RESET 8'he0
// ****************************************************************
// Timing
// ****************************************************************
`define CONV_CLOCKS 16
`endif

/* File: core/adc_window_detector.v */
// Converter sequencing, result capture and programmable window detector
//
// Operation
// - After each conversion, compare result with both limits and signal hits.
// - Hit is a sticky flag in control register, pollable or interrupt.
// - Two limit words, each split into writable high and low bytes.
// - Limit ordering selects inside-window or outside-window detection.
// - Lower limit high byte: 8-bit read/write at its address, resets zero.
// - Undivided clock setting: conversion takes at least sixteen clocks.
`timescale 1ns/1ns
`include "adc_window_map.vh"
module adc_window_detector #(
  parameter RES_WIDTH = 10,
  parameter CONV_CLOCKS = `CONV_CLOCKS
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  output reg [7:0] sfr_rdata_o,
  input wire [RES_WIDTH-1:0] conv_result_i,
  output wire window_hit_flag_o,
  output wire conv_done_o
);
  reg [7:0] converter_control_reg_r;
  reg [7:0] converter_config_reg_r;
  reg [7:0] converter_control_nxt;
  wire [7:0] upper_limit_high_byte;
  wire [7:0] upper_limit_low_byte;
  wire [7:0] lower_limit_high_byte;
  wire [7:0] lower_limit_low_byte;
  reg [15:0] result_r;
  reg [7:0] cycle_cnt_r;
  reg [7:0] div_cnt_r;
  reg busy_r;
  wire [15:0] upper_word;
  wire [15:0] lower_word;
  wire [15:0] sample;
  wire [2:0] div_sel;
  wire div_tick;
  wire conv_end;
  wire hit;
  wire wr_ctrl;
  wire start;

  // ****************************************************************
  // Window comparison
  // ****************************************************************
  assign upper_word = {upper_limit_high_byte, upper_limit_low_byte};
  assign lower_word = {lower_limit_high_byte, lower_limit_low_byte};
  assign sample = {{(16-RES_WIDTH){1'b0}}, conv_result_i};
  // Inside window when ordering inverted, else outside
  assign hit = (lower_word > upper_word) ?
    ((sample > upper_word) && (sample < lower_word)) :
    ((sample > upper_word) || (sample < lower_word));

  // ****************************************************************
  // Conversion timing
  // ****************************************************************
  assign div_sel = converter_config_reg_r[`CFG_DIV_MSB:`CFG_DIV_LSB];
  assign div_tick = (div_cnt_r == {5'h00, div_sel});
  assign conv_end = busy_r && div_tick &&
    (cycle_cnt_r == CONV_CLOCKS[7:0] - 8'h01);
  assign wr_ctrl = sfr_wr_i && (sfr_addr_i == `CONV_CTRL_ADDR);
  assign start = wr_ctrl && sfr_wdata_i[`CTRL_START_BIT] &&
    converter_control_reg_r[`CTRL_ENABLE_BIT] && !busy_r;
  assign window_hit_flag_o = converter_control_reg_r[`CTRL_HIT_BIT];
  assign conv_done_o = converter_control_reg_r[`CTRL_DONE_BIT];

  // Sequencer: divided clock ticks count out each conversion
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      cycle_cnt_r <= 8'h00;
      div_cnt_r <= 8'h00;
      result_r <= 16'h0000;
    end else begin
      if (start) begin
        busy_r <= 1'b1;
        cycle_cnt_r <= 8'h00;
        div_cnt_r <= 8'h00;
      end else if (busy_r) begin
        if (div_tick) begin
          div_cnt_r <= 8'h00;
          cycle_cnt_r <= cycle_cnt_r + 8'h01;
        end else begin
          div_cnt_r <= div_cnt_r + 8'h01;
        end
        if (conv_end) begin
          busy_r <= 1'b0;
          result_r <= sample;
        end
      end
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  // Control next value; hardware set of done and hit beats a software
  // clear written in the same cycle, so no conversion event is lost
  always @* begin
    converter_control_nxt = converter_control_reg_r;
    if (wr_ctrl) begin
      converter_control_nxt = {sfr_wdata_i[7:6],
        sfr_wdata_i[`CTRL_DONE_BIT], 2'b00,
        sfr_wdata_i[`CTRL_HIT_BIT], sfr_wdata_i[1:0]};
    end
    if (conv_end) begin
      converter_control_nxt[`CTRL_DONE_BIT] = 1'b1;
      if (hit) begin
        converter_control_nxt[`CTRL_HIT_BIT] = 1'b1;
      end
    end
  end

  // Control and configuration registers
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      converter_control_reg_r <= `BYTE_RESET;
      converter_config_reg_r <= `CFG_RESET;
    end else begin
      converter_control_reg_r <= converter_control_nxt;
      if (sfr_wr_i && sfr_addr_i == `CONV_CFG_ADDR) begin
        converter_config_reg_r <= sfr_wdata_i;
      end
    end
  end

  // ****************************************************************
  // Limit bytes
  // ****************************************************************
  // Greater-than word, high byte; resets to all ones
  limit_byte_reg #(
    .ADDR(`UPPER_HI_ADDR),
    .RESET(`UPPER_RESET)
  ) upper_hi_u (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_wr_i(sfr_wr_i),
    .byte_o(upper_limit_high_byte)
  );

  // Greater-than word, low byte; resets to all ones
  limit_byte_reg #(
    .ADDR(`UPPER_LO_ADDR),
    .RESET(`UPPER_RESET)
  ) upper_lo_u (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_wr_i(sfr_wr_i),
    .byte_o(upper_limit_low_byte)
  );

  // Less-than word, high byte; resets to zero
  limit_byte_reg #(
    .ADDR(`LOWER_HI_ADDR),
    .RESET(`BYTE_RESET)
  ) lower_hi_u (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_wr_i(sfr_wr_i),
    .byte_o(lower_limit_high_byte)
  );

  // Less-than word, low byte; resets to zero
  limit_byte_reg #(
    .ADDR(`LOWER_LO_ADDR),
    .RESET(`BYTE_RESET)
  ) lower_lo_u (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_wr_i(sfr_wr_i),
    .byte_o(lower_limit_low_byte)
  );

  // Registered read data; unmapped addresses read zero
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= `BYTE_RESET;
    end else if (sfr_rd_i) begin
      case (sfr_addr_i)
        `CONV_CTRL_ADDR: begin
          sfr_rdata_o <= converter_control_reg_r |
            ({7'h00, busy_r} << `CTRL_BUSY_BIT);
        end
        `CONV_CFG_ADDR: sfr_rdata_o <= converter_config_reg_r;
        `UPPER_HI_ADDR: sfr_rdata_o <= upper_limit_high_byte;
        `UPPER_LO_ADDR: sfr_rdata_o <= upper_limit_low_byte;
        `LOWER_HI_ADDR: sfr_rdata_o <= lower_limit_high_byte;
        `LOWER_LO_ADDR: sfr_rdata_o <= lower_limit_low_byte;
        `RESULT_HI_ADDR: sfr_rdata_o <= result_r[15:8];
        `RESULT_LO_ADDR: sfr_rdata_o <= result_r[7:0];
        default: sfr_rdata_o <= `BYTE_RESET;
      endcase
    end
  end
endmodule

// ****************************************************************
// Limit byte register
// ****************************************************************
// One writable limit byte; loads only when its own address is written
module limit_byte_reg #(
  parameter ADDR = `LOWER_HI_ADDR,
  parameter RESET = `BYTE_RESET
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  output wire [7:0] byte_o
);
  reg [7:0] byte_r;
  wire load;

  // Write strobe decoded for this byte only
  assign load = sfr_wr_i && (sfr_addr_i == ADDR[7:0]);
  assign byte_o = byte_r;

  // Storage with its own reset value
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      byte_r <= RESET[7:0];
    end else if (load) begin
      byte_r <= sfr_wdata_i;
    end
  end
endmodule

/* File: dv/adc_window_checker.sv */
// Port assertions for the window detector
`timescale 1ns/1ns
module adc_window_checker #(
  parameter RES_WIDTH = 10
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_rdata_o,
  input wire [RES_WIDTH-1:0] conv_result_i,
  input wire window_hit_flag_o,
  input wire conv_done_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Control write and enabled start write
  wire ctl_wr = sfr_wr_i && sfr_addr_i == 8'he8;
  wire go = ctl_wr && sfr_wdata_i[7] && sfr_wdata_i[4];
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_hold; window_hit_flag_o && !ctl_wr |=> window_hit_flag_o;
  endproperty
  property p_cause; $rose(window_hit_flag_o) |-> conv_done_o || $past(ctl_wr);
  endproperty
  property p_time;
    go |=> (!$rose(conv_done_o))[*8] ##1 (!$rose(conv_done_o))[*7];
  endproperty
  property p_lim;
    sfr_wr_i && sfr_addr_i[7:2] == 6'h31 ##2 sfr_rd_i &&
      sfr_addr_i == $past(sfr_addr_i, 2) |=>
      sfr_rdata_o == $past(sfr_wdata_i, 3);
  endproperty
  property p_rst; $fell(rst_i) |-> !window_hit_flag_o && !conv_done_o;
  endproperty
  property p_keep; !sfr_rd_i |=> $stable(sfr_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("hit dropped");
  a_cause: assert property (p_cause) else $error("hit no cause");
  a_time: assert property (p_time) else $error("early done");
  a_lim: assert property (p_lim) else $error("limit readback");
  a_rst: assert property (p_rst) else $error("flags after reset");
  a_keep: assert property (p_keep) else $error("rdata moved");
  c_hit: cover property (conv_done_o && window_hit_flag_o);
  c_miss: cover property (conv_done_o && !window_hit_flag_o);
  c_go: cover property (go);
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the window detector
`timescale 1ns/1ns
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] a = 8'h00;
  reg [7:0] d = 8'h00;
  reg w = 1'b0;
  reg r = 1'b0;
  reg [15:0] lw;
  reg [15:0] uw;
  reg [9:0] res = 10'h000;
  reg e;
  reg [42:0] rows [0:4];
  wire [7:0] q;
  wire hit;
  wire done;
  integer failures = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer i;
  integer n;
  adc_window_detector #(.RES_WIDTH(10), .CONV_CLOCKS(16)) dut_u (
    .sys_clk_i(clk), .rst_i(rst), .sfr_addr_i(a), .sfr_wdata_i(d),
    .sfr_wr_i(w), .sfr_rd_i(r), .sfr_rdata_o(q), .conv_result_i(res),
    .window_hit_flag_o(hit), .conv_done_o(done));
  // Clock and hang limit
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      failures = failures + 1;
      results;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Bus cycles with one idle clock after each
  task wr(input [7:0] ad, input [7:0] dt);
    begin
      a = ad;
      d = dt;
      w = 1'b1;
      @(posedge clk) #1 w = 1'b0;
      @(posedge clk) #1;
    end
  endtask
  task rd(input [7:0] ad, input [7:0] exp);
    begin
      a = ad;
      r = 1'b1;
      @(posedge clk) #1 r = 1'b0;
      @(posedge clk) #1 chk(q, exp);
    end
  endtask
  task results;
    begin
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  // Rows: lower word, upper word, result, expected hit
  initial begin
    rows[0] = {16'h0100, 16'h0200, 10'h080, 1'b1};
    rows[1] = {16'h0100, 16'h0200, 10'h150, 1'b0};
    rows[2] = {16'h0100, 16'h0200, 10'h200, 1'b0};
    rows[3] = {16'h0300, 16'h0100, 10'h200, 1'b1};
    rows[4] = {16'h0300, 16'h0100, 10'h300, 1'b0};
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    rd(8'hc7, 8'h00);
    rd(8'hc5, 8'hff);
    chk({6'h00, hit, done}, 8'h00);
    $display("power-up test done");
    wr(8'hbc, 8'h00);
    for (i = 0; i < 5; i = i + 1) begin
      {lw, uw, res, e} = rows[i];
      wr(8'hc7, lw[15:8]);
      rd(8'hc7, lw[15:8]);
      wr(8'hc6, lw[7:0]);
      wr(8'hc5, uw[15:8]);
      wr(8'hc4, uw[7:0]);
      rd(8'hc4, uw[7:0]);
      wr(8'he8, 8'h80);
      wr(8'he8, 8'h90);
      n = 0;
      while (done !== 1'b1 && n < 100) begin
        @(posedge clk) #1 n = n + 1;
      end
      chk({7'h00, n >= 15}, 8'h01);
      chk({6'h00, hit, done}, {6'h00, e, 1'b1});
      rd(8'hbf, {6'h00, res[9:8]});
      rd(8'hbe, res[7:0]);
      $display("row %0d done", i);
    end
    // Divide-by-two setting: 32 clocks; busy reads back meanwhile
    wr(8'hbc, 8'h20);
    wr(8'he8, 8'h80);
    wr(8'he8, 8'h90);
    rd(8'he8, 8'h88);
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      @(posedge clk) #1 n = n + 1;
    end
    // Three of the 32 clocks went by in the start write and busy read
    chk(n[7:0], 8'h1d);
    $display("divider test done");
    // Start with the enable clear is ignored; unmapped read gives zero
    wr(8'he8, 8'h00);
    wr(8'he8, 8'h10);
    repeat (40) @(posedge clk);
    #1 chk({7'h00, done}, 8'h00);
    rd(8'h00, 8'h00);
    $display("refusal test done");
    // Reset in mid-run restores the limits and clears the sticky flags
    wr(8'hc7, 8'h5a);
    wr(8'he8, 8'h84);
    chk({6'h00, hit, done}, 8'h02);
    rst = 1'b1;
    @(posedge clk) #1 rst = 1'b0;
    chk({6'h00, hit, done}, 8'h00);
    rd(8'hc7, 8'h00);
    rd(8'hc5, 8'hff);
    $display("mid-run reset test done");
    results;
  end
endmodule
bind adc_window_detector adc_window_checker #(.RES_WIDTH(RES_WIDTH)) chk_u (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
  .sfr_rdata_o(sfr_rdata_o), .conv_result_i(conv_result_i),
  .window_hit_flag_o(window_hit_flag_o), .conv_done_o(conv_done_o));
